// ### hdl/scs_clock_select.sv
// Purpose: System clock source select with fast RC and slow crystal sources.
// Assumes: Register strobes are one cycle long and synchronous to clk.
// Notes:   All clocks are enable pulses; a source switch waits for a whole
//          pulse of the old source unless the fast source is paused, so no shortened period ever appears.

`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Select field picks fast or slow clock, live.
// - Fast clock divided by one up to sixty-four.
// - Fast from internal RC, slow from crystal.
// - Both speed sources always exist, never none.
// - Crystal oscillator stays enabled at all times.
// - Crystal divided by eight feeds watchdog.
// - Display pump clock from crystal, rate selectable.
// - Crystal clock unused until start-up delay passes.
// - Slow internal RC never offered as clock.
// - Codes 0-6 divide fast clock, 7 slow.
// - Frequency codes: 4, 8, 12, 4 MHz.
// - Freq change clears stable flag, applies after set.
// - Switch to slow waits for crystal stable.
module scs_clock_select
   import scs_pkg::*;
#(
   parameter int XTAL_DIV = XTAL_DIV_DEF,   // Crystal period in clk cycles.
   parameter int FRC_START_CYC = 256,       // Fast RC start-up in clk cycles.
   parameter int XTAL_START_TICKS = 1024    // Crystal start-up in its own ticks.
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Register port.
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   // Clock enables out.
   output logic sys_clk_en,
   output logic crystal_clk_en,
   output logic watchdog_clk_en,
   output logic display_pump_clock_en,
   output logic [1:0] fast_rc_freq_act
);

   // Refuse parameter values that the counters below cannot serve.
   if (XTAL_DIV < 8 || XTAL_DIV >= (1 << XTAL_W)) begin : g_bad_xdiv
      $error("scs_clock_select: XTAL_DIV out of range.");
   end
   if (FRC_START_CYC < 1 || XTAL_START_TICKS < 1) begin : g_bad_start
      $error("scs_clock_select: start-up counts must be positive.");
   end

   localparam int FCW = $clog2(FRC_START_CYC + 1);
   localparam int XCW = $clog2(XTAL_START_TICKS + 1);

   ////////////////////////////////////////////////////////////////////////
   // Oscillator ticks.
   logic fast_tick;   // One fast RC period.
   logic xtal_tick;   // One crystal period.
   scs_frc_t frc_st_r, frc_st_nxt;   // Fast oscillator state.

   // The fast RC runs once stable at the applied frequency.
   scs_tick_gen #(.W(FRC_W)) u_fast (
      .clk(clk),
      .rst(rst),
      .run(frc_st_r == FRC_RUN),
      .period(frc_period(fast_rc_freq_act)),
      .tick(fast_tick)
   );

   // The crystal never stops, so its divider always runs.
   scs_tick_gen #(.W(XTAL_W)) u_xtal (
      .clk(clk),
      .rst(rst),
      .run(1'b1),
      .period(XTAL_W'(XTAL_DIV)),
      .tick(xtal_tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // Register state.
   logic [2:0] cks_req_r, cks_req_nxt;       // Requested system clock code.
   logic fhiden_r, fhiden_nxt;               // Fast oscillator in halt.
   logic fsiden_r, fsiden_nxt;               // Slow oscillator in halt.
   logic [1:0] fsel_r, fsel_nxt;             // Requested fast RC frequency.
   logic frc_en_r, frc_en_nxt;               // Fast RC enable bit.
   logic [2:0] pump_sel_r, pump_sel_nxt;     // Pump clock rate select.
   logic xtal_stable_r, xtal_stable_nxt;     // Crystal usable.
   logic [DATA_W-1:0] rdata_nxt;
   logic wr_scc, wr_frc, wr_dsp;

   // Decode writes and build read data for the next cycle.
   always_comb begin
      wr_scc = reg_wr && (reg_addr == SCC_OFS);
      wr_frc = reg_wr && (reg_addr == FRC_OFS);
      wr_dsp = reg_wr && (reg_addr == DSP_OFS);
      cks_req_nxt = wr_scc ? reg_wdata[CKS_MSB:CKS_LSB] : cks_req_r;
      fhiden_nxt = wr_scc ? reg_wdata[FHIDEN_BIT] : fhiden_r;
      fsiden_nxt = wr_scc ? reg_wdata[FSIDEN_BIT] : fsiden_r;
      fsel_nxt = wr_frc ? reg_wdata[FSEL_MSB:FSEL_LSB] : fsel_r;
      frc_en_nxt = wr_frc ? reg_wdata[EN_BIT] : frc_en_r;
      pump_sel_nxt = wr_dsp ? reg_wdata[PUMP_MSB:PUMP_LSB] : pump_sel_r;
      rdata_nxt = '0;
      if (reg_rd) begin
         case (reg_addr)
            SCC_OFS: rdata_nxt = {cks_req_r, 3'h0, fhiden_r, fsiden_r};
            FRC_OFS: rdata_nxt = {4'h0, fsel_r, frc_st_r == FRC_RUN, frc_en_r};
            XTC_OFS: rdata_nxt = {6'h00, xtal_stable_r, 1'b1};
            DSP_OFS: rdata_nxt = {5'h00, pump_sel_r};
            default: rdata_nxt = '0;
         endcase
      end
   end

   // Register the software-visible bits; read data stand one cycle only.
   always_ff @(posedge clk) begin
      if (rst) begin
         cks_req_r <= CKS_RST;
         fhiden_r <= 1'b0;
         fsiden_r <= 1'b0;
         fsel_r <= FSEL_RST;
         frc_en_r <= 1'b1;
         pump_sel_r <= PUMP_RST;
         reg_rdata <= '0;
      end else begin
         cks_req_r <= cks_req_nxt;
         fhiden_r <= fhiden_nxt;
         fsiden_r <= fsiden_nxt;
         fsel_r <= fsel_nxt;
         frc_en_r <= frc_en_nxt;
         pump_sel_r <= pump_sel_nxt;
         reg_rdata <= rdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Fast RC oscillator: start-up and frequency application.
   logic [FCW-1:0] frc_cnt_r, frc_cnt_nxt;   // Start-up cycles counted.
   logic [1:0] fact_nxt;                     // Applied frequency next.
   logic [2:0] active_cks_r, active_cks_nxt; // Code in force on the output.
   logic frc_need;

   // The fast RC keeps running while it drives the system clock, so the
   // high speed source is never left without an oscillator.
   always_comb begin
      frc_need = frc_en_r || (active_cks_r != CKS_SLOW) || (cks_req_r != CKS_SLOW);
      frc_st_nxt = frc_st_r;
      frc_cnt_nxt = frc_cnt_r;
      fact_nxt = fast_rc_freq_act;
      case (frc_st_r)
         FRC_OFF: begin
            if (frc_need) begin
               frc_st_nxt = FRC_START;
               frc_cnt_nxt = '0;
            end
         end
         FRC_START: begin
            if (!frc_need) begin
               frc_st_nxt = FRC_OFF;
            end else if (wr_frc && fsel_nxt != fsel_r) begin
               frc_cnt_nxt = '0;
            end else if (frc_cnt_r == FCW'(FRC_START_CYC - 1)) begin
               frc_st_nxt = FRC_RUN;
               fact_nxt = fsel_r;
            end else begin
               frc_cnt_nxt = frc_cnt_r + FCW'(1);
            end
         end
         FRC_RUN: begin
            if (!frc_need) begin
               frc_st_nxt = FRC_OFF;
            end else if (wr_frc && fsel_nxt != fsel_r) begin
               frc_st_nxt = FRC_START;
               frc_cnt_nxt = '0;
            end
         end
         default: frc_st_nxt = FRC_OFF;
      endcase
   end

   // Register the fast oscillator state.
   always_ff @(posedge clk) begin
      if (rst) begin
         frc_st_r <= FRC_START;
         frc_cnt_r <= '0;
         fast_rc_freq_act <= FSEL_RST;
      end else begin
         frc_st_r <= frc_st_nxt;
         frc_cnt_r <= frc_cnt_nxt;
         fast_rc_freq_act <= fact_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Crystal start-up and derived clocks; the slow internal RC is not
   // an input at all, so it can never reach these paths.
   logic [XCW-1:0] xst_cnt_r, xst_cnt_nxt;   // Crystal ticks since start.
   logic [7:0] xdiv_cnt_r, xdiv_cnt_nxt;     // Crystal divider chain.
   logic [7:0] pmask;
   logic wdt_nxt, pump_nxt, xclk_nxt;

   // Count crystal ticks to the start-up delay, then open the derived clocks.
   always_comb begin
      xst_cnt_nxt = xst_cnt_r;
      xtal_stable_nxt = xtal_stable_r;
      if (xtal_tick && !xtal_stable_r) begin
         if (xst_cnt_r == XCW'(XTAL_START_TICKS - 1)) begin
            xtal_stable_nxt = 1'b1;
         end else begin
            xst_cnt_nxt = xst_cnt_r + XCW'(1);
         end
      end
      xdiv_cnt_nxt = (xtal_tick && xtal_stable_r) ? xdiv_cnt_r + 8'h01 : xdiv_cnt_r;
      pmask = ones_mask(4'({1'b0, pump_sel_r} + 4'h1));
      xclk_nxt = xtal_tick && xtal_stable_r;
      wdt_nxt = xclk_nxt && (xdiv_cnt_r[2:0] == WDT_DIV_MASK);
      pump_nxt = xclk_nxt && ((xdiv_cnt_r & pmask) == pmask);
   end

   // Register the crystal state and its clock enables.
   always_ff @(posedge clk) begin
      if (rst) begin
         xst_cnt_r <= '0;
         xtal_stable_r <= 1'b0;
         xdiv_cnt_r <= '0;
         crystal_clk_en <= 1'b0;
         watchdog_clk_en <= 1'b0;
         display_pump_clock_en <= 1'b0;
      end else begin
         xst_cnt_r <= xst_cnt_nxt;
         xtal_stable_r <= xtal_stable_nxt;
         xdiv_cnt_r <= xdiv_cnt_nxt;
         crystal_clk_en <= xclk_nxt;
         watchdog_clk_en <= wdt_nxt;
         display_pump_clock_en <= pump_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // System clock multiplexer.
   logic [5:0] pre_cnt_r, pre_cnt_nxt;   // Fast clock prescaler.
   logic old_tick;                       // Pulse of the code in force.
   logic fast_idle;                      // Fast source paused.
   logic do_switch;
   logic skip_r, skip_nxt;               // Swallow the first pulse of a new code.

   // Tick of a given code: prescaled fast clock, or the crystal.
   function automatic logic code_tick(input logic [2:0] code, input logic [5:0] pc,
                                      input logic ft, input logic xt);
      logic [7:0] m;
      m = ones_mask({1'b0, code});
      if (code == CKS_SLOW) code_tick = xt;
      else code_tick = ft && ((pc & m[5:0]) == m[5:0]);
   endfunction : code_tick

   // Change codes at the end of a whole pulse of the old source, or at once while the fast source is paused.
   always_comb begin
      pre_cnt_nxt = fast_tick ? pre_cnt_r + 6'h01 : pre_cnt_r;
      old_tick = code_tick(active_cks_r, pre_cnt_r, fast_tick, xclk_nxt);
      fast_idle = (active_cks_r != CKS_SLOW) && (frc_st_r != FRC_RUN);
      do_switch = (cks_req_r != active_cks_r) && (old_tick || fast_idle) && !skip_r
                  && ((cks_req_r != CKS_SLOW) || xtal_stable_r);
      active_cks_nxt = do_switch ? cks_req_r : active_cks_r;
      // The new source may tick right after the old one: drop that first pulse.
      skip_nxt = do_switch || (skip_r && !old_tick);
   end

   // Register the prescaler, the code in force and the system clock.
   always_ff @(posedge clk) begin
      if (rst) begin
         pre_cnt_r <= '0;
         active_cks_r <= CKS_RST;
         skip_r <= 1'b0;
         sys_clk_en <= 1'b0;
      end else begin
         pre_cnt_r <= pre_cnt_nxt;
         active_cks_r <= active_cks_nxt;
         skip_r <= skip_nxt;
         sys_clk_en <= old_tick && !skip_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_slow_stable;
      $changed(active_cks_r) && active_cks_r == CKS_SLOW |-> xtal_stable_r;
   endproperty
   a_slow_stable: assert property (p_slow_stable) else $error("slow switch unstable");

   property p_switch_edge;
      $changed(active_cks_r) && !$past(fast_idle) |-> sys_clk_en;
   endproperty
   a_switch_edge: assert property (p_switch_edge) else $error("switch mid period");

   sequence s_quiet;
      !sys_clk_en [*4];
   endsequence
   property p_no_runt;
      sys_clk_en |=> s_quiet;
   endproperty
   a_no_runt: assert property (p_no_runt) else $error("runt system clock");

   property p_freq_clear;
      wr_frc && reg_wdata[FSEL_MSB:FSEL_LSB] != fsel_r && frc_st_r != FRC_OFF
         |=> frc_st_r != FRC_RUN;
   endproperty
   a_freq_clear: assert property (p_freq_clear) else $error("flag not cleared");

   property p_freq_apply;
      $changed(fast_rc_freq_act) |-> frc_st_r == FRC_RUN && $past(frc_st_r) == FRC_START;
   endproperty
   a_freq_apply: assert property (p_freq_apply) else $error("freq applied early");

   property p_xtal_en;
      reg_rd && reg_addr == XTC_OFS |=> reg_rdata[EN_BIT];
   endproperty
   a_xtal_en: assert property (p_xtal_en) else $error("crystal shown disabled");

   property p_gate;
      !xtal_stable_r |=> !watchdog_clk_en && !display_pump_clock_en && !crystal_clk_en;
   endproperty
   a_gate: assert property (p_gate) else $error("crystal used early");

   property p_wdt;
      watchdog_clk_en |-> crystal_clk_en && $past(xdiv_cnt_r[2:0]) == WDT_DIV_MASK;
   endproperty
   a_wdt: assert property (p_wdt) else $error("watchdog clock wrong");

   property p_slow_src;
      $past(active_cks_r) == CKS_SLOW && sys_clk_en |-> crystal_clk_en;
   endproperty
   a_slow_src: assert property (p_slow_src) else $error("slow source wrong");

endmodule : scs_clock_select

`default_nettype wire

// ### hdl/scs_pkg.sv
// Purpose: Shared constants for the system clock source select block.
// Assumes: One 250 MHz clock; slower clocks are one-cycle enable pulses.
// Notes:   Register map, field layout, reset values and divider figures.

package scs_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register port shape and register offsets.
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam logic [ADDR_W-1:0] SCC_OFS = 4'h0;   // System clock control.
   localparam logic [ADDR_W-1:0] FRC_OFS = 4'h1;   // Fast RC control.
   localparam logic [ADDR_W-1:0] XTC_OFS = 4'h2;   // Slow crystal control.
   localparam logic [ADDR_W-1:0] DSP_OFS = 4'h3;   // Display control.

   ////////////////////////////////////////////////////////////////////////
   // Field positions.
   localparam int CKS_MSB = 7;
   localparam int CKS_LSB = 5;
   localparam int FHIDEN_BIT = 1;
   localparam int FSIDEN_BIT = 0;
   localparam int FSEL_MSB = 3;
   localparam int FSEL_LSB = 2;
   localparam int FLAG_BIT = 1;
   localparam int EN_BIT = 0;
   localparam int PUMP_MSB = 2;
   localparam int PUMP_LSB = 0;

   ////////////////////////////////////////////////////////////////////////
   // Codes and reset values.
   localparam logic [2:0] CKS_SLOW = 3'h7;   // Low speed clock.
   localparam logic [2:0] CKS_RST = 3'h1;    // Fast clock divided by two.
   localparam logic [1:0] FSEL_RST = 2'h0;
   localparam logic [2:0] PUMP_RST = 3'h0;
   localparam logic [2:0] WDT_DIV_MASK = 3'h7;  // Crystal divided by eight.

   ////////////////////////////////////////////////////////////////////////
   // Timing: fast RC periods and crystal period in system clock cycles.
   localparam int CLK_KHZ = 250000;
   localparam int FRC_4M_KHZ = 4000;
   localparam int FRC_8M_KHZ = 8000;
   localparam int FRC_12M_KHZ = 12000;
   localparam int FRC_W = 7;
   localparam logic [FRC_W-1:0] FRC_DIV_4M = FRC_W'(CLK_KHZ / FRC_4M_KHZ);
   localparam logic [FRC_W-1:0] FRC_DIV_8M = FRC_W'(CLK_KHZ / FRC_8M_KHZ);
   localparam logic [FRC_W-1:0] FRC_DIV_12M = FRC_W'(CLK_KHZ / FRC_12M_KHZ);
   localparam int CLK_HZ = 250000000;
   localparam int XTAL_HZ = 32768;
   localparam int XTAL_W = 13;
   localparam int XTAL_DIV_DEF = CLK_HZ / XTAL_HZ;

   // Fast RC period for a frequency select code; code 3 is 4 MHz.
   function automatic logic [FRC_W-1:0] frc_period(input logic [1:0] sel);
      case (sel)
         2'h1: frc_period = FRC_DIV_8M;
         2'h2: frc_period = FRC_DIV_12M;
         default: frc_period = FRC_DIV_4M;
      endcase
   endfunction : frc_period

   // Mask of n low ones, used by the prescaler and the pump divider.
   function automatic logic [7:0] ones_mask(input logic [3:0] n);
      ones_mask = 8'((9'h001 << n) - 9'h001);
   endfunction : ones_mask

   // Fast oscillator states.
   typedef enum logic [1:0] {FRC_OFF, FRC_START, FRC_RUN} scs_frc_t;

endpackage : scs_pkg

// ### hdl/scs_tick_gen.sv
// Purpose: Divider that turns the system clock into an oscillator tick.
// Assumes: Period of at least two cycles; run low clears the divider.
// Notes:   The tick is one cycle long and comes from a flip-flop.

`timescale 1ns/1ps
`default_nettype none

module scs_tick_gen #(
   parameter int W = 8
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Control.
   input wire logic run,
   input wire logic [W-1:0] period,
   // Tick out.
   output logic tick
);

   // Refuse a counter too narrow to hold a two-cycle period.
   if (W < 2) begin : g_bad_w
      $error("scs_tick_gen: W must be at least 2.");
   end

   logic [W-1:0] cnt_r;    // Cycles since the last tick.
   logic [W-1:0] cnt_nxt;
   logic tick_nxt;

   // Count up to period-1, then wrap and fire; stopped counter restarts at zero.
   always_comb begin
      cnt_nxt = cnt_r;
      tick_nxt = 1'b0;
      if (!run) begin
         cnt_nxt = '0;
      end else if (cnt_r >= period - W'(1)) begin
         cnt_nxt = '0;
         tick_nxt = 1'b1;
      end else begin
         cnt_nxt = cnt_r + W'(1);
      end
   end

   // Register the counter and the tick.
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_r <= '0;
         tick <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         tick <= tick_nxt;
      end
   end

endmodule : scs_tick_gen

`default_nettype wire

// ### test/scs_clock_select_tb_top.sv
// Purpose: Self-checking bench for the system clock source select block.
// Assumes: Short start-up and crystal figures set through the parameters.
// Notes:   Table rows cover clock codes and pump rates; hand tests come before and after.

`timescale 1ns/1ps
`default_nettype none

module scs_clock_select_tb_top;
   import scs_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Shortened counts; every crystal and start-up expectation is derived from these.
   localparam int XD = 16;       // Crystal period in clk cycles.
   localparam int FS = 8;        // Fast RC start-up in clk cycles.
   localparam int XS = 2;        // Crystal start-up in crystal ticks.
   localparam int LIMIT = 90000; // Cycle ceiling for the whole run.

   // One table row: register write, watched output and expected period.
   typedef struct {int kind; logic [ADDR_W-1:0] addr; logic [7:0] wdata; int per;} scs_row_t;

   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [DATA_W-1:0] reg_rdata;
   logic sys_clk_en, crystal_clk_en, watchdog_clk_en, display_pump_clock_en;
   logic [1:0] fast_rc_freq_act;
   int mismatches = 0;
   int n_checks = 0;
   int cyc = 0;
   int xt_pulses = 0;
   int gap = 0;
   int min_gap = 1000000;
   scs_row_t rows[16];

   scs_clock_select #(.XTAL_DIV(XD), .FRC_START_CYC(FS), .XTAL_START_TICKS(XS))
      scs_clock_select_inst (.clk(clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .sys_clk_en(sys_clk_en), .crystal_clk_en(crystal_clk_en),
      .watchdog_clk_en(watchdog_clk_en), .display_pump_clock_en(display_pump_clock_en),
      .fast_rc_freq_act(fast_rc_freq_act));

   // Clock at 250 MHz.
   always #2 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////
   // Monitors: cut a hang short, count early crystal pulses, track gaps.
   always @(posedge clk) begin
      cyc++;
      if (crystal_clk_en === 1'b1 || watchdog_clk_en === 1'b1) xt_pulses++;
      if (sys_clk_en === 1'b1) begin
         if (gap < min_gap) min_gap = gap;
         gap = 0;
      end else begin
         gap++;
      end
      if (cyc == LIMIT) begin
         mismatches++;
         print_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Compare tasks and the closing report.
   task automatic chk_reg(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : chk_reg

   task automatic chk_cnt(input string name, input int exp, input int got);
      n_checks++;
      if (got != exp) begin
         mismatches++;
         $display("mismatch %s expected %0d seen %0d", name, exp, got);
      end
   endtask : chk_cnt

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict

   ////////////////////////////////////////////////////////////////////////
   // Register port: one-cycle strobes, read data in the following cycle.
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd

   task automatic rd_chk(input string name, input logic [ADDR_W-1:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      chk_reg(name, e, d);
   endtask : rd_chk

   // Reset held five cycles; every output must sit at zero meanwhile.
   task automatic do_reset();
      @(posedge clk);
      rst <= 1'b1;
      repeat (4) begin
         @(posedge clk);
         #1;
         chk_reg("outs_in_reset", 8'h00, reg_rdata | {2'h0, fast_rc_freq_act, sys_clk_en,
                 crystal_clk_en, watchdog_clk_en, display_pump_clock_en});
      end
      @(posedge clk);
      rst <= 1'b0;
      xt_pulses = 0;
   endtask : do_reset

   // Picks a watched pulse output: 0 system, 1 watchdog, 2 pump, 3 crystal.
   function automatic logic pick(input int k);
      pick = (k == 0) ? sys_clk_en : (k == 1) ? watchdog_clk_en :
             (k == 2) ? display_pump_clock_en : crystal_clk_en;
   endfunction : pick

   // Period between the third and fourth pulses, so a switch has settled.
   task automatic measure(input int k, output int per);
      int n;
      int c;
      per = 0;
      for (n = 0; n < 4; n++) begin
         c = 0;
         do begin
            @(posedge clk);
            #1;
            c++;
         end while (pick(k) !== 1'b1 && c < 9000);
         per = c;
      end
   endtask : measure

   // Fast clock period in clk cycles for a frequency code.
   function automatic int frc_cyc(input int s);
      frc_cyc = (s == 1) ? 31 : (s == 2) ? 20 : 62;
   endfunction : frc_cyc

   ////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      int per;
      int prev;
      for (int i = 0; i < 8; i++) begin
         rows[i] = '{0, SCC_OFS, {i[2:0], 5'h00}, (i == 7) ? XD : (62 << i)};
         rows[i + 8] = '{2, DSP_OFS, {5'h00, i[2:0]}, (2 * XD) << i};
      end
      do_reset();
      // Reset values and early flags, before either oscillator settles.
      rd_chk("frc_ctrl_rst", FRC_OFS, 8'h01);
      rd_chk("xtc_rst", XTC_OFS, 8'h01);
      @(posedge clk);
      #1;
      chk_reg("rdata_after", 8'h00, reg_rdata);
      rd_chk("scc_rst", SCC_OFS, 8'h20);
      rd_chk("dsp_rst", DSP_OFS, 8'h00);
      rd_chk("unmapped", 4'hF, 8'h00);
      chk_cnt("early_xtal_pulses", 0, xt_pulses);
      repeat (XS * XD + 16) @(posedge clk);
      rd_chk("xtc_stable", XTC_OFS, 8'h03);
      rd_chk("frc_stable", FRC_OFS, 8'h03);
      // Read-only crystal control, ignored unmapped write, implemented bits.
      wr(XTC_OFS, 8'h00);
      rd_chk("xtc_ro", XTC_OFS, 8'h03);
      wr(4'h8, 8'hFF);
      rd_chk("unmapped_wr", 4'h8, 8'h00);
      wr(SCC_OFS, 8'hFF);
      rd_chk("scc_bits", SCC_OFS, 8'hE3);
      measure(1, per);
      chk_cnt("watchdog_period", 8 * XD, per);
      measure(3, per);
      chk_cnt("crystal_period", XD, per);
      // Table: every system clock code and every pump rate.
      foreach (rows[i]) begin
         wr(rows[i].addr, rows[i].wdata);
         measure(rows[i].kind, per);
         chk_cnt($sformatf("period_row%0d", i), rows[i].per, per);
      end
      // Frequency changes under the undivided fast clock.
      wr(SCC_OFS, 8'h00);
      prev = 0;
      for (int s = 1; s < 5; s++) begin
         wr(FRC_OFS, {4'h0, 2'(s), 2'h1});
         rd_chk("frc_restart", FRC_OFS, {4'h0, 2'(s), 2'h1});
         chk_reg("freq_held", 8'(prev), {6'h00, fast_rc_freq_act});
         repeat (FS + 4) @(posedge clk);
         rd_chk("frc_settled", FRC_OFS, {4'h0, 2'(s), 2'h3});
         chk_reg("freq_act", {6'h00, 2'(s)}, {6'h00, fast_rc_freq_act});
         measure(0, per);
         chk_cnt("fast_period", frc_cyc(s % 4), per);
         prev = s % 4;
      end
      chk_cnt("no_short_sys_pulse", 1, int'(min_gap >= 5));
      // Clearing the enable cannot stop the fast RC while it drives the clock.
      wr(FRC_OFS, 8'h00);
      rd_chk("frc_kept", FRC_OFS, 8'h02);
      // Mid-run reset returns the default divide-by-two selection.
      do_reset();
      rd_chk("scc_rst2", SCC_OFS, 8'h20);
      print_verdict();
   end

endmodule : scs_clock_select_tb_top

`default_nettype wire
